// ---- src/jesd_tx_link_control_defines.svh ----
/*
 * Constants of the transmit link control block: register indices, reset
 * values, control characters and frame geometry.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef JESD_TX_LINK_CONTROL_DEFINES_SVH
`define JESD_TX_LINK_CONTROL_DEFINES_SVH

`define TEST_ALIGN_IDX     12'h571
`define SYNC_CODING_IDX    12'h572
`define LINK_STATUS_IDX    12'h580
`define TEST_ALIGN_RESET   8'h14
`define SYNC_CODING_RESET  8'h00
`define TEST_ALIGN_WMASK   8'h3f
`define SYNC_CODING_WMASK  8'hf4
`define CHAR_CGS           8'hbc
`define CHAR_LANE_ALIGN    8'h7c
`define CHAR_FRAME_ALIGN   8'hfc
`define CHAR_MF_START      8'h1c
`define CHAR_CONFIG_START  8'h9c
`define LONG_TEST_NIBBLE   4'ha
`define MF_OCTETS          8
`define MF_LAST            3'h7
`define ILAS_MF_LAST       2'h3
`define SAMPLE_WIDTH       8
`define FIFO_DEPTH         8

`endif

// ---- src/jesd_tx_link_control_pkg.sv ----
/*
 * Types of the transmit link control block.
 * Assumes the defines header is on the include path.
 */
package jesd_tx_link_control_pkg;
	`include "jesd_tx_link_control_defines.svh"

	typedef struct packed {
		logic [1:0] unused;
		logic       long_test;
		logic       lane_sync;
		logic [1:0] ilas_mode;
		logic       faci_off;
		logic       link_pd;
	} test_align_t;

	typedef struct packed {
		logic [1:0] sync_mode;
		logic       sync_invert;
		logic       sync_single;
		logic       reserved;
		logic       bypass;
		logic [1:0] unused;
	} sync_coding_t;

	typedef struct packed {
		logic       encode;
		logic       k;
		logic [9:0] symbol;
	} tx_char_t;

	typedef enum logic [3:0] {
		ST_PD   = 4'b0001,
		ST_CGS  = 4'b0010,
		ST_ILAS = 4'b0100,
		ST_DATA = 4'b1000
	} link_state_t;

	typedef enum logic [1:0] {
		SYNC_NORMAL     = 2'b00,
		SYNC_FORCE_CGS  = 2'b10,
		SYNC_FORCE_ILAS = 2'b11
	} sync_mode_t;

	typedef enum logic [1:0] {
		ILAS_OFF    = 2'b00,
		ILAS_ON     = 2'b01,
		ILAS_REPEAT = 2'b11
	} ilas_mode_t;
endpackage : jesd_tx_link_control_pkg

// ---- src/sample_fifo.sv ----
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/10ps
module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb
	begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push)
		begin
			next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop)
		begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop)
		begin
			next_count = count + 1'b1;
		end
		else if (pop && !push)
		begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready <= (next_count != (AW+1)'(DEPTH));
			out_valid <= (next_count != '0);
		end
	end

	always_ff @(posedge hclk)
	begin
		if (push)
		begin
			mem[wr_ptr] <= in_data;
		end
	end

	assign out_data = mem[rd_ptr];
endmodule : sample_fifo

// ---- src/jesd_tx_link_control.sv ----
/*
 * Transmit link control: AHB-Lite register slave, sync request handling,
 * link state machine, alignment character insertion and test samples.
 * Assumes sample data and sync request inputs synchronous to hclk.
 */
// Summary of operation
// - Long test bit replaces samples with test sequence.
// - Lane sync picks K28.3 and K28.7, else K28.7.
// - Alignment mode 00 skips, 01 sends ILAS.
// - Alignment mode 11 repeats ILAS continuously.
// - Alignment character insertion off only when bit set.
// - Link enabled sends K28.5 per sync request.
// - Link control one powers down, resets, gates.
// - Sync mode 10 ignores request, forces K28.5.
// - Sync mode 11 ignores request, runs ILAS, data.
// - Invert bit inverts received sync request.
// - Type bit selects differential or positive input.
// - Bypass sends raw octet, top bits zero.
`timescale 1ns/10ps
`include "jesd_tx_link_control_defines.svh"
module jesd_tx_link_control
	import jesd_tx_link_control_pkg::*;
(
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	input  wire logic                     sync_request_positive_input,
	input  wire logic                     sync_request_pair_n,
	input  wire logic                     sample_valid,
	input  wire logic [`SAMPLE_WIDTH-1:0] sample_data,
	output logic                          sample_ready,
	output tx_char_t                      tx_char,
	output logic                          link_clock_enable,
	output logic                          link_reset
);
	function automatic logic [11:0] word_index(input logic [31:0] addr);
		word_index = addr[13:2];
	endfunction : word_index

	function automatic logic [7:0] merge(input logic [7:0] old_value,
		input logic [7:0] wdata, input logic [7:0] wmask);
		merge = (old_value & ~wmask) | (wdata & wmask);
	endfunction : merge

	test_align_t              test_align;
	sync_coding_t             sync_coding;
	logic                     dphase_write;
	logic [11:0]              dphase_idx;
	test_align_t              next_test_align;
	sync_coding_t             next_sync_coding;
	logic                     next_dphase_write;
	logic [11:0]              next_dphase_idx;
	logic [31:0]              next_hrdata;
	logic                     addr_phase;

	link_state_t              state;
	logic [2:0]               octet_cnt;
	logic [1:0]               ilas_mf;
	logic [7:0]               prev_last;
	logic                     sync_held;
	link_state_t              next_state;
	logic [2:0]               next_octet_cnt;
	logic [1:0]               next_ilas_mf;
	logic [7:0]               next_prev_last;
	logic                     next_sync_held;
	tx_char_t                 next_tx_char;

	logic                     fifo_valid;
	logic [`SAMPLE_WIDTH-1:0] fifo_data;
	logic                     fifo_pop;
	logic                     fifo_in_ready;
	logic                     sync_level;
	logic                     sync_requested;
	logic                     go;
	logic                     restart;
	logic                     mf_end;
	logic                     frame_end;
	logic                     pd;
	logic [7:0]               octet;
	logic                     octet_k;

	sample_fifo #(
		.WIDTH (`SAMPLE_WIDTH),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (sample_valid),
		.in_data   (sample_data),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (fifo_pop)
	);

	// Register slave: zero wait states, write applied in the data phase.
	always_comb
	begin
		addr_phase = hsel && htrans[1] && hready;
		next_dphase_write = addr_phase && hwrite;
		next_dphase_idx = addr_phase ? word_index(haddr) : dphase_idx;
		next_test_align = test_align;
		next_sync_coding = sync_coding;
		if (dphase_write && dphase_idx == `TEST_ALIGN_IDX)
		begin
			next_test_align = merge(test_align, hwdata[7:0], `TEST_ALIGN_WMASK);
		end
		if (dphase_write && dphase_idx == `SYNC_CODING_IDX)
		begin
			next_sync_coding = merge(sync_coding, hwdata[7:0], `SYNC_CODING_WMASK);
		end
		next_hrdata = hrdata;
		if (addr_phase && !hwrite)
		begin
			case (word_index(haddr))
				`TEST_ALIGN_IDX:  next_hrdata = {24'h000000, next_test_align};
				`SYNC_CODING_IDX: next_hrdata = {24'h000000, next_sync_coding};
				`LINK_STATUS_IDX: next_hrdata = {20'h00000, fifo_valid,
					sync_held, octet_cnt, ilas_mf, 1'b0, state};
				default:          next_hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			test_align <= `TEST_ALIGN_RESET;
			sync_coding <= `SYNC_CODING_RESET;
			dphase_write <= 1'b0;
			dphase_idx <= 12'h000;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			test_align <= next_test_align;
			sync_coding <= next_sync_coding;
			dphase_write <= next_dphase_write;
			dphase_idx <= next_dphase_idx;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Sync request decode and link sequencing.
	always_comb
	begin
		pd = test_align.link_pd;
		sync_level = sync_coding.sync_single ? sync_request_positive_input
			: (sync_request_positive_input && !sync_request_pair_n);
		sync_requested = !(sync_level ^ sync_coding.sync_invert);
		go = (sync_coding.sync_mode == SYNC_FORCE_ILAS)
			|| (sync_coding.sync_mode != SYNC_FORCE_CGS && !sync_requested);
		restart = (sync_coding.sync_mode == SYNC_FORCE_CGS)
			|| (sync_coding.sync_mode != SYNC_FORCE_ILAS && sync_requested);
		mf_end = (octet_cnt == `MF_LAST);
		frame_end = octet_cnt[0];
		next_octet_cnt = pd ? 3'h0 : 3'(octet_cnt + 3'h1);
		next_ilas_mf = ilas_mf;
		next_state = state;
		next_sync_held = sync_requested;
		next_prev_last = prev_last;
		fifo_pop = 1'b0;
		octet = `CHAR_CGS;
		octet_k = 1'b1;
		case (state)
			ST_PD:
			begin
				next_ilas_mf = 2'h0;
				if (!pd)
				begin
					next_state = ST_CGS;
				end
			end
			ST_CGS:
			begin
				next_ilas_mf = 2'h0;
				if (pd)
				begin
					next_state = ST_PD;
				end
				else if (go && mf_end)
				begin
					next_state = (test_align.ilas_mode == ILAS_OFF) ? ST_DATA : ST_ILAS;
				end
			end
			ST_ILAS:
			begin
				octet_k = 1'b0;
				octet = {3'h0, ilas_mf, octet_cnt};
				if (octet_cnt == 3'h0)
				begin
					octet = `CHAR_MF_START;
					octet_k = 1'b1;
				end
				else if (mf_end)
				begin
					octet = `CHAR_LANE_ALIGN;
					octet_k = 1'b1;
				end
				else if (ilas_mf == 2'h1 && octet_cnt == 3'h1)
				begin
					octet = `CHAR_CONFIG_START;
					octet_k = 1'b1;
				end
				if (mf_end)
				begin
					next_ilas_mf = 2'(ilas_mf + 2'h1);
				end
				if (pd)
				begin
					next_state = ST_PD;
				end
				else if (restart)
				begin
					next_state = ST_CGS;
				end
				else if (mf_end && ilas_mf == `ILAS_MF_LAST
					&& test_align.ilas_mode != ILAS_REPEAT)
				begin
					next_state = ST_DATA;
				end
			end
			ST_DATA:
			begin
				octet_k = 1'b0;
				fifo_pop = fifo_valid;
				octet = fifo_valid ? fifo_data : 8'h00;
				if (test_align.long_test)
				begin
					octet = {octet_cnt, 1'b0, `LONG_TEST_NIBBLE};
				end
				if (frame_end)
				begin
					next_prev_last = octet;
					if (octet == prev_last && !test_align.faci_off)
					begin
						octet_k = 1'b1;
						octet = (mf_end && test_align.lane_sync)
							? `CHAR_LANE_ALIGN : `CHAR_FRAME_ALIGN;
					end
				end
				if (pd)
				begin
					next_state = ST_PD;
				end
				else if (restart)
				begin
					next_state = ST_CGS;
				end
				else if (mf_end && test_align.ilas_mode == ILAS_REPEAT)
				begin
					next_state = ST_ILAS;
					next_ilas_mf = 2'h0;
				end
			end
			default:
			begin
				next_state = ST_PD;
			end
		endcase
		next_tx_char.encode = !sync_coding.bypass;
		next_tx_char.k = octet_k && !sync_coding.bypass;
		next_tx_char.symbol = {2'b00, octet};
		if (!sync_coding.bypass)
		begin
			next_tx_char.symbol = {1'b0, octet_k, octet};
		end
		if (state == ST_PD)
		begin
			next_tx_char = '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= ST_PD;
			octet_cnt <= 3'h0;
			ilas_mf <= 2'h0;
			prev_last <= 8'h00;
			sync_held <= 1'b0;
			tx_char <= '0;
			link_clock_enable <= 1'b0;
			link_reset <= 1'b1;
			sample_ready <= 1'b0;
		end
		else
		begin
			state <= next_state;
			octet_cnt <= next_octet_cnt;
			ilas_mf <= next_ilas_mf;
			prev_last <= next_prev_last;
			sync_held <= next_sync_held;
			tx_char <= next_tx_char;
			link_clock_enable <= !next_test_align.link_pd;
			link_reset <= next_test_align.link_pd;
			sample_ready <= fifo_in_ready;
		end
	end
endmodule : jesd_tx_link_control

// ---- testbench/jesd_tx_link_control_properties.sv ----
/*
 * Port checker of the transmit link control block.
 * Assumes a bind to the top module with one clock and reset.
 */
`timescale 1ns/10ps
`include "jesd_tx_link_control_defines.svh"
module jesd_tx_link_control_properties
	import jesd_tx_link_control_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire tx_char_t    tx_char,
	input  wire logic        link_clock_enable,
	input  wire logic        link_reset
);
	logic [31:0] ta;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	assign ta = {18'h0, `TEST_ALIGN_IDX, 2'b00};

	a_link_gated: assert property (link_reset != link_clock_enable)
		else $error("link clock enable disagrees with link reset");
	a_pd_silent: assert property (link_reset [*3] |-> tx_char == 12'h000)
		else $error("characters sent while powered down");
	a_pd_write: assert property (hsel && htrans[1] && hready && hwrite && haddr == ta
		##1 hwdata[0] |-> ##[1:4] link_reset)
		else $error("link not powered down after write");
	a_run_write: assert property (hsel && htrans[1] && hready && hwrite && haddr == ta
		##1 !hwdata[0] |-> ##[1:4] !link_reset)
		else $error("link not running after write");
	a_raw_top: assert property (!tx_char.encode |-> tx_char[11:8] == 4'h0)
		else $error("raw symbol has top bits set");
	a_coded_top: assert property (tx_char.encode |-> tx_char.symbol[9:8] == {1'b0, tx_char.k})
		else $error("coded symbol top bits wrong");
	a_ilas_end: assert property (tx_char == 12'hd1c |-> ##7 (tx_char == 12'hd7c
		|| tx_char == 12'hdbc || link_reset))
		else $error("alignment multiframe not closed on its eighth octet");
	a_ilas_entry: assert property (tx_char == 12'hd1c |-> $past(tx_char) == 12'hdbc
		|| $past(tx_char) == 12'hd7c)
		else $error("alignment sequence started off a multiframe boundary");
	a_cgs_first: assert property ($fell(link_reset) |-> ##[1:3] tx_char == 12'hdbc)
		else $error("no sync character after link start");
endmodule : jesd_tx_link_control_properties

// ---- testbench/sync_receiver_model.sv ----
/*
 * Receiver end model: drives the sync request from the characters it sees.
 * Assumes the block's clock and reset; the bench steers its options.
 */
`timescale 1ns/10ps
module sync_receiver_model
	import jesd_tx_link_control_pkg::*;
(
	input  wire logic     hclk,
	input  wire logic     hresetn,
	input  wire tx_char_t tx_char,
	input  wire logic     demand,
	input  wire logic     slow,
	input  wire logic     invert,
	input  wire logic     single_ended,
	output logic          sync_request_positive_input,
	output logic          sync_request_pair_n
);
	logic [4:0] seen;
	logic       toggle;
	logic       released;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			seen <= 5'h00;
			toggle <= 1'b0;
		end
		else
		begin
			toggle <= ~toggle;
			if (demand || (!released && tx_char !== 12'hdbc))
				seen <= 5'h00;
			else if (!released)
				seen <= seen + 5'h01;
		end
	end

	// Request stays low until enough sync characters came in a row.
	assign released = !demand && seen >= (slow ? 5'h18 : 5'h04);
	assign sync_request_positive_input = released ^ invert;
	assign sync_request_pair_n = single_ended ? toggle : ~sync_request_positive_input;
endmodule : sync_receiver_model

// ---- testbench/testbench.sv ----
/*
 * Bench of the transmit link control block: bus tasks and scenarios.
 * Assumes the design, the receiver model and the checker compiled first.
 */
`timescale 1ns/10ps
`include "jesd_tx_link_control_defines.svh"
module testbench
	import jesd_tx_link_control_pkg::*;
;
	localparam logic [31:0] TA = {18'h0, `TEST_ALIGN_IDX, 2'b00};
	localparam logic [31:0] SC = {18'h0, `SYNC_CODING_IDX, 2'b00};
	logic        hclk, hresetn, hsel, hwrite, sample_valid, sample_ready;
	logic        link_clock_enable, link_reset, demand, slow, invert, single;
	logic        sync_request_positive_input, sync_request_pair_n, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [7:0]  sample_data;
	logic [31:0] haddr, hwdata, hrdata;
	tx_char_t    tx_char;
	int          failures, compares;

	jesd_tx_link_control u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.sync_request_positive_input, .sync_request_pair_n, .sample_valid,
		.sample_data, .sample_ready, .tx_char, .link_clock_enable, .link_reset);
	sync_receiver_model u_rx (.hclk, .hresetn, .tx_char, .demand, .slow, .invert,
		.single_ended(single), .sync_request_positive_input, .sync_request_pair_n);

	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	task automatic conclude;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic rdy;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		chk("hready", 1, hreadyout);
		conclude;
	endtask : rdy

	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		rdy;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		rdy;
		q = hrdata;
		chk("hresp", 0, hresp);
	endtask : bus

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic look(input string n, input tx_char_t c, input int len, exp);
		int k;
		k = 0;
		repeat (4) @(posedge hclk);
		repeat (len)
		begin
			@(posedge hclk);
			k += int'(tx_char === c);
		end
		chk(n, exp, k);
	endtask : look

	task automatic seek(input string n, input tx_char_t c);
		for (int i = 0; i < 600; i++)
		begin
			@(posedge hclk);
			if (tx_char === c)
				return;
		end
		chk(n, c, tx_char);
		conclude;
	endtask : seek

	task automatic to_cgs(input logic [31:0] d);
		demand <= 1'b1;
		wr(TA, d);
		seek("cgs", 12'hdbc);
	endtask : to_cgs

	task automatic rejoin;
		to_cgs(32'h14);
		demand <= 1'b0;
		seek("data", 12'hdfc);
	endtask : rejoin

	task automatic t_regs;
		logic [31:0] q;
		bus(1'b0, TA, 0, q);
		chk("test_align", 32'h14, q);
		bus(1'b0, SC, 0, q);
		chk("sync_coding", 32'h00, q);
		wr(TA, 32'hd4);
		bus(1'b0, TA, 0, q);
		chk("reserved", 32'h14, q);
		wr(SC, 32'h08);
		bus(1'b0, SC, 0, q);
		chk("reserved", 32'h00, q);
		bus(1'b0, 32'h4, 0, q);
		chk("unmapped", 32'h00, q);
		$display("regs end");
	endtask : t_regs

	task automatic t_up;
		seek("cgs", 12'hdbc);
		seek("ilas", 12'hd1c);
		seek("frame", 12'hdfc);
		look("lane_end", 12'hd7c, 8, 1);
		slow <= 1'b0;
		wr(TA, 32'h04);
		look("k28_7_only", 12'hdfc, 16, 8);
		wr(TA, 32'h06);
		look("faci_off", 12'h800, 16, 16);
		wr(TA, 32'h14);
		$display("link up end");
	endtask : t_up

	task automatic t_long;
		wr(TA, 32'h34);
		look("long_test", 12'h8ea, 8, 1);
		wr(SC, 32'h04);
		look("bypass", 12'h0ea, 8, 1);
		wr(SC, 0);
		wr(TA, 32'h14);
		look("samples", 12'h8ea, 8, 0);
		$display("long test end");
	endtask : t_long

	task automatic t_power;
		wr(TA, 32'h15);
		look("power_down", 12'h000, 8, 8);
		chk("gated", 32'h1, {30'h0, link_clock_enable, link_reset});
		wr(TA, 32'h14);
		seek("restart", 12'hdbc);
		seek("restart", 12'hdfc);
		$display("power end");
	endtask : t_power

	task automatic t_force;
		wr(SC, 32'h80);
		look("force_cgs", 12'hdbc, 16, 16);
		demand <= 1'b1;
		wr(SC, 32'hc0);
		seek("force_ilas", 12'hd1c);
		seek("force_data", 12'hdfc);
		wr(SC, 0);
		rejoin;
		$display("force end");
	endtask : t_force

	task automatic t_repeat;
		to_cgs(32'h1c);
		demand <= 1'b0;
		seek("repeat", 12'hd1c);
		look("repeat", 12'hd1c, 64, 8);
		rejoin;
		to_cgs(32'h10);
		demand <= 1'b0;
		look("skipped", 12'hd1c, 48, 0);
		$display("alignment modes end");
	endtask : t_repeat

	task automatic t_sync;
		wr(SC, 32'h20);
		look("inverted", 12'hdbc, 16, 16);
		invert <= 1'b1;
		seek("inverted", 12'hdfc);
		invert <= 1'b0;
		single <= 1'b1;
		wr(SC, 32'h10);
		seek("single", 12'hdfc);
		look("single", 12'hdbc, 32, 0);
		wr(SC, 0);
		seek("pair", 12'hdbc);
		single <= 1'b0;
		$display("sync input end");
	endtask : t_sync

	task automatic t_fifo;
		to_cgs(32'h10);
		for (int i = 0; i < 8; i++)
		begin
			sample_valid <= 1'b1;
			sample_data <= 8'ha1 + 8'(i);
			@(posedge hclk);
		end
		sample_valid <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("full", 0, sample_ready);
		demand <= 1'b0;
		seek("drain", 12'h8a1);
		for (int i = 1; i < 9; i++)
		begin
			@(posedge hclk);
			chk("drain", i < 8 ? 12'h8a1 + 12'(i) : 12'h800, tx_char);
		end
		chk("empty", 1, sample_ready);
		$display("fifo end");
	endtask : t_fifo

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 0;
		sample_valid = 1'b0;
		sample_data = 8'h00;
		demand = 1'b0;
		slow = 1'b1;
		invert = 1'b0;
		single = 1'b0;
		failures = 0;
		compares = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_up;
		t_long;
		t_power;
		t_force;
		t_repeat;
		t_sync;
		t_fifo;
		conclude;
	end
endmodule : testbench

bind jesd_tx_link_control jesd_tx_link_control_properties u_props (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .tx_char, .link_clock_enable, .link_reset);
